// >>> wel_defines.svh
`ifndef WEL_DEFINES_SVH
`define WEL_DEFINES_SVH

// ----------------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------------
`define WEL_OFS_RESET_CAUSE 16'h28b0
`define WEL_OFS_WAKE_SOURCE 16'h28b1
`define WEL_OFS_TIMER_ARM 16'h28b2
`define WEL_OFS_PIN_ENABLE 16'h28b3
`define WEL_OFS_OPTICAL_CTRL 16'h2457
`define WEL_OFS_TIMER_PERIOD 16'h28b8

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define WEL_BIT_COLD_START 7
`define WEL_BIT_RESET_PIN 6
`define WEL_BIT_SW_RESET 5
`define WEL_BIT_WATCHDOG 4
`define WEL_BIT_EMU_RESET 3
`define WEL_BIT_LOW_BATTERY 2
`define WEL_BIT_TIMER_FLAG 5
`define WEL_BIT_SERIAL 4
`define WEL_BIT_BUTTON 3
`define WEL_BIT_PIN_FOUR 2
`define WEL_BIT_PIN_FIFTY_TWO 1
`define WEL_BIT_PIN_FIFTY_FIVE 0
`define WEL_BIT_SLEEP_REQ 7
`define WEL_BIT_DISPLAY_REQ 6
`define WEL_BIT_TIMER_ARM 5
`define WEL_BIT_OPT_DISABLE 2

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define WEL_ENABLE_RST 5'h00
`define WEL_ARM_RST 1'b0
`define WEL_OPT_DISABLE_RST 1'b0
`define WEL_TIMER_PERIOD_RST 8'h10

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define WEL_CLK_PERIOD_NS 4
`define WEL_SHORT_FILTER_NS 2000
`define WEL_SHORT_FILTER_CYCLES \
  ((`WEL_SHORT_FILTER_NS + `WEL_CLK_PERIOD_NS - 1) / `WEL_CLK_PERIOD_NS)
`define WEL_SAMPLE_PERIOD_NS 2000000
`define WEL_SAMPLE_CYCLES (`WEL_SAMPLE_PERIOD_NS / `WEL_CLK_PERIOD_NS)
`define WEL_QUAL_TIME_MS 64
`define WEL_SAMPLE_TIME_MS 2
`define WEL_QUAL_SAMPLES (`WEL_QUAL_TIME_MS / `WEL_SAMPLE_TIME_MS)

`endif

// >>> wel_pkg.sv
package wel_pkg;

  typedef enum logic [1:0] {
    WEL_MISSION_FULL_POWER_MODE = 2'b00,
    WEL_BROWNOUT_BATTERY_MODE = 2'b01,
    WEL_SLEEP_BATTERY_MODE = 2'b10,
    WEL_DISPLAY_RETENTION_MODE = 2'b11
  } wel_mode_t;

  typedef struct packed {
    logic timer;
    logic serial;
    logic button;
    logic pin_four;
    logic pin_fifty_two;
    logic pin_fifty_five;
  } wel_wake_src_t;

endpackage

// >>> wel_wake_event_logic.sv
// Local design decision: the plain strobed port.
`timescale 1ns/100ps
`include "wel_defines.svh"

// ----------------------------------------------------------------------------
// short filter: two-stage synchroniser, then a level must stand 2 us
// ----------------------------------------------------------------------------
module wel_short_filter #(
  parameter int unsigned CYCLES = `WEL_SHORT_FILTER_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_pin,
  output logic o_level
);
  logic sync1_reg;
  logic sync2_reg;
  logic [9:0] stable_cnt_reg;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
    end else begin
      sync1_reg <= i_pin;
      sync2_reg <= sync1_reg;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      stable_cnt_reg <= 10'h000;
      o_level <= 1'b0;
    end else if (sync2_reg == o_level) begin
      stable_cnt_reg <= 10'h000;
    end else if (stable_cnt_reg == 10'(CYCLES - 1)) begin
      stable_cnt_reg <= 10'h000;
      o_level <= sync2_reg;
    end else begin
      stable_cnt_reg <= stable_cnt_reg + 10'h001;
    end
  end
endmodule // wel_short_filter

// ----------------------------------------------------------------------------
// long filter: sampled every 2 ms, high accepted after 64 ms of high samples
// ----------------------------------------------------------------------------
module wel_level_qual (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_pin,
  input wire logic i_sample,
  output logic o_high
);
  logic sync1_reg;
  logic sync2_reg;
  logic [5:0] high_cnt_reg;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
    end else begin
      sync1_reg <= i_pin;
      sync2_reg <= sync1_reg;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      high_cnt_reg <= 6'h00;
      o_high <= 1'b0;
    end else if (i_sample) begin
      if (!sync2_reg) begin
        high_cnt_reg <= 6'h00;
        o_high <= 1'b0;
      end else if (high_cnt_reg == 6'(`WEL_QUAL_SAMPLES - 1)) begin
        o_high <= 1'b1;
      end else begin
        high_cnt_reg <= high_cnt_reg + 6'h01;
      end
    end
  end
endmodule // wel_level_qual

// ----------------------------------------------------------------------------
// top
// ----------------------------------------------------------------------------
// How it works
// - power return always forces mission mode
// - armed timer expiry wakes, sets timer flag
// - serial pin either edge wakes, 2 us filter
// - pin four rising edge wakes, 2 us filter
// - button or pin 52 high level wakes
// - optical disable set: pin 55 high wakes
// - optical disable clear: optical pin edge wakes
// - sample every 2 ms, accept 64 ms high
// - after first accepted transition, ignore later ones, except the button
// - processor held in reset while asleep
// - wake event raises wake within three slow cycles
// - flag records which source caused the wake
// - button flag sets on every press
// - reset cause flags always recorded, emulator reset only when emulation enabled
// - power return sets no wake flag
// - pin flag held clear when not configured
// - flags clear when wake falls, wake flags also when their source is disabled, cause flags on a new cause
module wel_wake_event_logic #(
  parameter int unsigned SAMPLE_CYCLES = `WEL_SAMPLE_CYCLES
) (
  input wire logic I_CLK_SYS,
  input wire logic I_RESETN,
  input wire logic [15:0] I_ADDR,
  input wire logic [7:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  input wire logic I_BUTTON_WAKE_INPUT,
  input wire logic I_SERIAL_RX,
  input wire logic I_MULTIPURPOSE_PIN_FOUR,
  input wire logic I_MULTIPURPOSE_PIN_FIFTY_TWO,
  input wire logic I_MULTIPURPOSE_PIN_FIFTY_FIVE,
  input wire logic I_OPTICAL_RECEIVE_PIN,
  input wire logic [2:0] I_PIN_DIGITAL_INPUT_CFG,
  input wire logic I_SYSTEM_POWER_OK,
  input wire logic I_RESET_PIN,
  input wire logic I_EMU_RESET_PIN,
  input wire logic I_EMU_ENABLE,
  input wire logic I_BATTERY_LOW,
  input wire logic I_SW_RESET,
  input wire logic I_WATCHDOG_OVERFLOW,
  input wire logic I_COLD_START,
  output logic [7:0] O_RDATA,
  output logic O_WAKE,
  output logic O_CPU_RESET_N,
  output wel_pkg::wel_mode_t O_MODE
);

  // --------------------------------------------------------------------------
  // synchronisers and filters
  // --------------------------------------------------------------------------
  logic [2:0] lvl_sync1_reg;
  logic [2:0] lvl_sync2_reg;
  logic power_ok_s;
  logic emu_enable_s;
  logic battery_low_s;
  logic [19:0] sample_cnt_reg;
  logic sample_tick_reg;
  logic serial_f;
  logic pin_four_f;
  logic optical_f;
  logic reset_pin_f;
  logic emu_reset_f;
  logic button_q;
  logic pin_fifty_two_q;
  logic pin_fifty_five_q;

  always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
    if (!I_RESETN) begin
      lvl_sync1_reg <= 3'h0;
      lvl_sync2_reg <= 3'h0;
    end else begin
      lvl_sync1_reg <= {I_SYSTEM_POWER_OK, I_EMU_ENABLE, I_BATTERY_LOW};
      lvl_sync2_reg <= lvl_sync1_reg;
    end
  end

  assign power_ok_s = lvl_sync2_reg[2];
  assign emu_enable_s = lvl_sync2_reg[1];
  assign battery_low_s = lvl_sync2_reg[0];

  // one shared 2 ms sample tick for all long filters and the wake timer
  always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
    if (!I_RESETN) begin
      sample_cnt_reg <= 20'h00000;
      sample_tick_reg <= 1'b0;
    end else if (sample_cnt_reg == 20'(SAMPLE_CYCLES - 1)) begin
      sample_cnt_reg <= 20'h00000;
      sample_tick_reg <= 1'b1;
    end else begin
      sample_cnt_reg <= sample_cnt_reg + 20'h00001;
      sample_tick_reg <= 1'b0;
    end
  end

  wel_short_filter u_serial_filt (.i_clk(I_CLK_SYS), .i_resetn(I_RESETN),
    .i_pin(I_SERIAL_RX), .o_level(serial_f));
  wel_short_filter u_pin_four_filt (.i_clk(I_CLK_SYS), .i_resetn(I_RESETN),
    .i_pin(I_MULTIPURPOSE_PIN_FOUR), .o_level(pin_four_f));
  wel_short_filter u_optical_filt (.i_clk(I_CLK_SYS), .i_resetn(I_RESETN),
    .i_pin(I_OPTICAL_RECEIVE_PIN), .o_level(optical_f));
  wel_short_filter u_reset_pin_filt (.i_clk(I_CLK_SYS), .i_resetn(I_RESETN),
    .i_pin(I_RESET_PIN), .o_level(reset_pin_f));
  wel_short_filter u_emu_reset_filt (.i_clk(I_CLK_SYS), .i_resetn(I_RESETN),
    .i_pin(I_EMU_RESET_PIN), .o_level(emu_reset_f));
  wel_level_qual u_button_qual (.i_clk(I_CLK_SYS), .i_resetn(I_RESETN),
    .i_pin(I_BUTTON_WAKE_INPUT), .i_sample(sample_tick_reg), .o_high(button_q));
  wel_level_qual u_fifty_two_qual (.i_clk(I_CLK_SYS), .i_resetn(I_RESETN),
    .i_pin(I_MULTIPURPOSE_PIN_FIFTY_TWO), .i_sample(sample_tick_reg),
    .o_high(pin_fifty_two_q));
  wel_level_qual u_fifty_five_qual (.i_clk(I_CLK_SYS), .i_resetn(I_RESETN),
    .i_pin(I_MULTIPURPOSE_PIN_FIFTY_FIVE), .i_sample(sample_tick_reg),
    .o_high(pin_fifty_five_q));

  // --------------------------------------------------------------------------
  // software registers
  // --------------------------------------------------------------------------
  logic [4:0] pin_enable_reg;
  logic timer_arm_reg;
  logic optical_disable_reg;
  logic [7:0] timer_period_reg;
  logic sleep_req_reg;
  logic display_req_reg;

  always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
    if (!I_RESETN) begin
      pin_enable_reg <= `WEL_ENABLE_RST;
      timer_arm_reg <= `WEL_ARM_RST;
      optical_disable_reg <= `WEL_OPT_DISABLE_RST;
      timer_period_reg <= `WEL_TIMER_PERIOD_RST;
    end else if (I_WR) begin
      case (I_ADDR)
        `WEL_OFS_PIN_ENABLE: pin_enable_reg <= I_WDATA[4:0];
        `WEL_OFS_TIMER_ARM: timer_arm_reg <= I_WDATA[`WEL_BIT_TIMER_ARM];
        `WEL_OFS_OPTICAL_CTRL: optical_disable_reg <= I_WDATA[`WEL_BIT_OPT_DISABLE];
        `WEL_OFS_TIMER_PERIOD: timer_period_reg <= I_WDATA;
        default: ;
      endcase
    end
  end

  // sleep and display requests are one-cycle strobes, never stored
  always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
    if (!I_RESETN) begin
      sleep_req_reg <= 1'b0;
      display_req_reg <= 1'b0;
    end else begin
      sleep_req_reg <= I_WR && (I_ADDR == `WEL_OFS_TIMER_ARM) && I_WDATA[`WEL_BIT_SLEEP_REQ];
      display_req_reg <= I_WR && (I_ADDR == `WEL_OFS_TIMER_ARM)
        && I_WDATA[`WEL_BIT_DISPLAY_REQ];
    end
  end

  // --------------------------------------------------------------------------
  // wake sources
  // --------------------------------------------------------------------------
  wel_pkg::wel_mode_t mode_reg;
  logic asleep;
  logic serial_prev_reg;
  logic pin_four_prev_reg;
  logic optical_prev_reg;
  logic [7:0] timer_cnt_reg;
  logic timer_expired;
  logic pin_four_ok;
  logic fifty_two_ok;
  logic fifty_five_ok;
  wel_pkg::wel_wake_src_t event_src;
  wel_pkg::wel_wake_src_t allowed_src;
  logic wake_event;

  assign asleep = (mode_reg == wel_pkg::WEL_SLEEP_BATTERY_MODE)
    || (mode_reg == wel_pkg::WEL_DISPLAY_RETENTION_MODE);

  always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
    if (!I_RESETN) begin
      serial_prev_reg <= 1'b0;
      pin_four_prev_reg <= 1'b0;
      optical_prev_reg <= 1'b0;
    end else begin
      serial_prev_reg <= serial_f;
      pin_four_prev_reg <= pin_four_f;
      optical_prev_reg <= optical_f;
    end
  end

  // the timer runs only while armed and asleep, counted in 2 ms ticks
  always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
    if (!I_RESETN) begin
      timer_cnt_reg <= 8'h00;
    end else if (!(timer_arm_reg && asleep)) begin
      timer_cnt_reg <= 8'h00;
    end else if (sample_tick_reg && (timer_cnt_reg != timer_period_reg)) begin
      timer_cnt_reg <= timer_cnt_reg + 8'h01;
    end
  end

  assign timer_expired = timer_arm_reg && asleep && (timer_cnt_reg == timer_period_reg);

  // pins not set up as digital inputs can never produce a wake
  assign pin_four_ok = pin_enable_reg[`WEL_BIT_PIN_FOUR] && I_PIN_DIGITAL_INPUT_CFG[0];
  assign fifty_two_ok = pin_enable_reg[`WEL_BIT_PIN_FIFTY_TWO]
    && I_PIN_DIGITAL_INPUT_CFG[1];
  assign fifty_five_ok = pin_enable_reg[`WEL_BIT_PIN_FIFTY_FIVE]
    && I_PIN_DIGITAL_INPUT_CFG[2];

  always_comb begin
    allowed_src.timer = timer_arm_reg;
    allowed_src.serial = pin_enable_reg[`WEL_BIT_SERIAL];
    allowed_src.button = pin_enable_reg[`WEL_BIT_BUTTON];
    allowed_src.pin_four = pin_four_ok;
    allowed_src.pin_fifty_two = fifty_two_ok;
    allowed_src.pin_fifty_five = fifty_five_ok;
    event_src.timer = timer_expired;
    event_src.serial = allowed_src.serial && (serial_f != serial_prev_reg);
    event_src.button = allowed_src.button && button_q;
    event_src.pin_four = pin_four_ok && pin_four_f && !pin_four_prev_reg;
    event_src.pin_fifty_two = fifty_two_ok && pin_fifty_two_q;
    if (optical_disable_reg) begin
      event_src.pin_fifty_five = fifty_five_ok && pin_fifty_five_q;
    end else begin
      event_src.pin_fifty_five = fifty_five_ok && (optical_f != optical_prev_reg);
    end
  end

  assign wake_event = asleep && (|event_src);

  // --------------------------------------------------------------------------
  // battery mode sequencing
  // --------------------------------------------------------------------------
  always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
    if (!I_RESETN) begin
      mode_reg <= wel_pkg::WEL_MISSION_FULL_POWER_MODE;
    end else if (power_ok_s) begin
      mode_reg <= wel_pkg::WEL_MISSION_FULL_POWER_MODE;
    end else begin
      case (mode_reg)
        wel_pkg::WEL_MISSION_FULL_POWER_MODE: begin
          mode_reg <= wel_pkg::WEL_BROWNOUT_BATTERY_MODE;
        end
        wel_pkg::WEL_BROWNOUT_BATTERY_MODE: begin
          if (sleep_req_reg) begin
            mode_reg <= wel_pkg::WEL_SLEEP_BATTERY_MODE;
          end else if (display_req_reg) begin
            mode_reg <= wel_pkg::WEL_DISPLAY_RETENTION_MODE;
          end
        end
        wel_pkg::WEL_SLEEP_BATTERY_MODE, wel_pkg::WEL_DISPLAY_RETENTION_MODE: begin
          if (wake_event) begin
            mode_reg <= wel_pkg::WEL_BROWNOUT_BATTERY_MODE;
          end
        end
        default: mode_reg <= wel_pkg::WEL_MISSION_FULL_POWER_MODE;
      endcase
    end
  end

  assign O_MODE = mode_reg;

  // wake follows the mode one edge later, so it rises two cycles after the event
  always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
    if (!I_RESETN) begin
      O_WAKE <= 1'b1;
      O_CPU_RESET_N <= 1'b0;
    end else begin
      O_WAKE <= !asleep;
      O_CPU_RESET_N <= !asleep && !reset_pin_f
        && !(emu_reset_f && emu_enable_s);
    end
  end

  // --------------------------------------------------------------------------
  // wake and reset-cause flags
  // --------------------------------------------------------------------------
  logic wake_fall;
  wel_pkg::wel_wake_src_t wake_flags_reg;
  wel_pkg::wel_wake_src_t wake_set;
  logic reset_pin_prev_reg;
  logic emu_reset_prev_reg;
  logic battery_low_prev_reg;
  logic [4:0] cause_set;
  logic [4:0] cause_flags_reg;
  logic low_battery_flag_reg;
  logic low_battery_set;

  assign wake_fall = O_WAKE && asleep;

  // only the source that ends a sleep is recorded; once awake, further edges
  // are ignored, except the button, which is recorded on every press
  always_comb begin
    wake_set = asleep ? event_src : '0;
    wake_set.button = event_src.button;
  end

  always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
    if (!I_RESETN) begin
      wake_flags_reg <= '0;
    end else begin
      // set wins over the clear of wake falling; power return sets nothing
      wake_flags_reg <= ((wake_flags_reg & ~{6{wake_fall}}) | wake_set)
        & allowed_src;
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
    if (!I_RESETN) begin
      reset_pin_prev_reg <= 1'b0;
      emu_reset_prev_reg <= 1'b0;
      battery_low_prev_reg <= 1'b0;
    end else begin
      reset_pin_prev_reg <= reset_pin_f;
      emu_reset_prev_reg <= emu_reset_f;
      battery_low_prev_reg <= battery_low_s;
    end
  end

  // order: cold start, reset pin, reset bit, watchdog, emulator reset
  assign cause_set = {I_COLD_START, reset_pin_f && !reset_pin_prev_reg, I_SW_RESET,
    I_WATCHDOG_OVERFLOW, emu_reset_f && !emu_reset_prev_reg && emu_enable_s};
  assign low_battery_set = battery_low_s && !battery_low_prev_reg;

  // a new restart cause replaces the older ones; low battery stands apart
  always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
    if (!I_RESETN) begin
      cause_flags_reg <= 5'h00;
      low_battery_flag_reg <= 1'b0;
    end else begin
      if (|cause_set) begin
        cause_flags_reg <= cause_set;
      end else if (wake_fall) begin
        cause_flags_reg <= 5'h00;
      end
      if (low_battery_set) begin
        low_battery_flag_reg <= 1'b1;
      end else if (wake_fall) begin
        low_battery_flag_reg <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------------
  // read port
  // --------------------------------------------------------------------------
  always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
    if (!I_RESETN) begin
      O_RDATA <= 8'h00;
    end else if (I_RD) begin
      case (I_ADDR)
        `WEL_OFS_RESET_CAUSE: O_RDATA <= {cause_flags_reg, low_battery_flag_reg, 2'h0};
        `WEL_OFS_WAKE_SOURCE: O_RDATA <= {2'h0, wake_flags_reg};
        `WEL_OFS_TIMER_ARM: O_RDATA <= {2'h0, timer_arm_reg, 3'h0, mode_reg};
        `WEL_OFS_PIN_ENABLE: O_RDATA <= {3'h0, pin_enable_reg};
        `WEL_OFS_OPTICAL_CTRL: O_RDATA <= {5'h00, optical_disable_reg, 2'h0};
        `WEL_OFS_TIMER_PERIOD: O_RDATA <= timer_period_reg;
        default: O_RDATA <= 8'h00;
      endcase
    end else begin
      O_RDATA <= 8'h00;
    end
  end

endmodule // wel_wake_event_logic

// >>> wel_monitor.sv
`timescale 1ns/100ps
// ----
// port checker for the wake block
// ----
module wel_monitor #(
  parameter int unsigned SAMPLE_CYCLES = 500000
) (
  input wire logic I_CLK_SYS,
  input wire logic I_RESETN,
  input wire logic I_RD,
  input wire logic I_SYSTEM_POWER_OK,
  input wire logic [7:0] O_RDATA,
  input wire logic O_WAKE,
  input wire logic O_CPU_RESET_N,
  input wire wel_pkg::wel_mode_t O_MODE
);
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_RESETN);
  logic asleep;
  // sleep and display retention both carry bit 1 of the mode code
  assign asleep = O_MODE[1];
  a_cpu_held_asleep: assert property (asleep && $past(asleep) |-> !O_CPU_RESET_N)
    else $error("processor left out of reset while asleep");
  a_asleep_no_wake: assert property (asleep && $past(asleep) |-> !O_WAKE)
    else $error("wake high while asleep");
  a_wake_after_exit: assert property ($past(asleep) && O_MODE == wel_pkg::WEL_BROWNOUT_BATTERY_MODE
    |=> O_WAKE && O_CPU_RESET_N)
    else $error("wake or processor late after leaving sleep");
  a_power_mission: assert property (I_SYSTEM_POWER_OK [*4] |->
    O_MODE == wel_pkg::WEL_MISSION_FULL_POWER_MODE)
    else $error("system power present but not in mission mode");
  a_power_awake: assert property (I_SYSTEM_POWER_OK [*5] |-> O_WAKE)
    else $error("system power present but wake low");
  a_rdata_idle: assert property (!$past(I_RD) |-> O_RDATA == 8'h00)
    else $error("read data outside its cycle");
  a_wake_fall_sleep: assert property ($fell(O_WAKE) |-> ##[0:2] asleep)
    else $error("wake fell without entering sleep");
  a_exit_brownout: assert property ($past(asleep) && !asleep && !I_SYSTEM_POWER_OK &&
    !$past(I_SYSTEM_POWER_OK) && !$past(I_SYSTEM_POWER_OK, 2)
    |-> O_MODE == wel_pkg::WEL_BROWNOUT_BATTERY_MODE)
    else $error("event wake did not land in brownout");
  c_wake_event: cover property ($past(asleep) && !asleep);
  c_sleep_entry: cover property ($fell(O_WAKE));
  c_read: cover property ($past(I_RD));
endmodule // wel_monitor

bind wel_wake_event_logic wel_monitor #(.SAMPLE_CYCLES(SAMPLE_CYCLES)) u_monitor (
  .I_CLK_SYS(I_CLK_SYS), .I_RESETN(I_RESETN), .I_RD(I_RD),
  .I_SYSTEM_POWER_OK(I_SYSTEM_POWER_OK), .O_RDATA(O_RDATA), .O_WAKE(O_WAKE),
  .O_CPU_RESET_N(O_CPU_RESET_N), .O_MODE(O_MODE));

// >>> wel_pin_model.sv
`timescale 1ns/100ps
// ----
// external wake pins: button, serial line, multipurpose pins
// ----
module wel_pin_model (
  input wire logic i_clk,
  output logic o_button,
  output logic o_serial,
  output logic o_pin_four,
  output logic o_pin_fifty_two,
  output logic o_pin_fifty_five,
  output logic o_optical
);
  // button pulled low, serial and optical lines idle high
  initial begin
    o_button = 1'b0;
    o_serial = 1'b1;
    o_pin_four = 1'b0;
    o_pin_fifty_two = 1'b0;
    o_pin_fifty_five = 1'b0;
    o_optical = 1'b1;
  end
  task automatic drive(input int idx, input logic lvl, input int hold);
    int n;
    // no level shorter than 2 us, or a filtered pin may miss it
    n = (hold < 500) ? 500 : hold;
    @(posedge i_clk);
    case (idx)
      0: o_button <= lvl;
      1: o_serial <= lvl;
      3: o_optical <= lvl;
      default: o_pin_four <= lvl;
    endcase
    repeat (n) @(posedge i_clk);
    // hand back once the flops launched on this edge have settled
    #1;
  endtask
endmodule // wel_pin_model

// >>> tb.sv
`timescale 1ns/100ps
`include "wel_defines.svh"
`define CHK(what, exp, got) \
  n_compared++; \
  if ((got) !== (exp)) begin \
    bad_count++; \
    $display("FAIL %s expected %h seen %h", what, exp, got); \
  end
// ----
// bench
// ----
module tb;
  logic clk, resetn, wr, rd, power_ok, sw_rst, wdog, cold, wake, cpu_resetn;
  logic button, serial, pin4, pin52, pin55, optical;
  logic [15:0] addr;
  logic [7:0] wdata, rdata;
  logic [2:0] cfg;
  wel_pkg::wel_mode_t mode;
  int bad_count, n_compared;
  wel_pin_model pins (.i_clk(clk), .o_button(button), .o_serial(serial), .o_pin_four(pin4),
    .o_pin_fifty_two(pin52), .o_pin_fifty_five(pin55), .o_optical(optical));
  // short sample period keeps the 32-sample qualification near 640 cycles
  wel_wake_event_logic #(.SAMPLE_CYCLES(20)) dut (
    .I_CLK_SYS(clk), .I_RESETN(resetn), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr),
    .I_RD(rd), .I_BUTTON_WAKE_INPUT(button), .I_SERIAL_RX(serial),
    .I_MULTIPURPOSE_PIN_FOUR(pin4), .I_MULTIPURPOSE_PIN_FIFTY_TWO(pin52),
    .I_MULTIPURPOSE_PIN_FIFTY_FIVE(pin55), .I_OPTICAL_RECEIVE_PIN(optical),
    .I_PIN_DIGITAL_INPUT_CFG(cfg), .I_SYSTEM_POWER_OK(power_ok), .I_RESET_PIN(1'b0),
    .I_EMU_RESET_PIN(1'b0), .I_EMU_ENABLE(1'b0), .I_BATTERY_LOW(1'b0), .I_SW_RESET(sw_rst),
    .I_WATCHDOG_OVERFLOW(wdog), .I_COLD_START(cold), .O_RDATA(rdata), .O_WAKE(wake),
    .O_CPU_RESET_N(cpu_resetn), .O_MODE(mode));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input string what, input logic [15:0] a, input logic [7:0] exp);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    `CHK(what, exp, rdata)
  endtask
  task automatic wait_wake(input logic lvl, input int n);
    int k;
    k = 0;
    while (wake !== lvl && k < n) begin
      @(posedge clk);
      #1;
      k++;
    end
    if (wake !== lvl) begin
      bad_count++;
      $display("FAIL wake expected %h seen %h", lvl, wake);
      close_out();
    end
  endtask
  // ctl carries the sleep request and, for the timer case, the arm bit
  task automatic go_sleep(input logic [7:0] ctl);
    wr_reg(`WEL_OFS_TIMER_ARM, ctl);
    wait_wake(1'b0, 20);
    repeat (3) @(posedge clk);
    #1;
    `CHK("mode", wel_pkg::WEL_SLEEP_BATTERY_MODE, mode)
    `CHK("cpu reset", 1'b0, cpu_resetn)
  endtask
  task automatic t_regs();
    rd_chk("enables", `WEL_OFS_PIN_ENABLE, 8'h00);
    rd_chk("flags", `WEL_OFS_WAKE_SOURCE, 8'h00);
    rd_chk("optical", `WEL_OFS_OPTICAL_CTRL, 8'h00);
    rd_chk("unmapped", 16'h0000, 8'h00);
    sw_rst <= 1'b1;
    @(posedge clk);
    sw_rst <= 1'b0;
    rd_chk("sw cause", `WEL_OFS_RESET_CAUSE, 8'h20);
    wdog <= 1'b1;
    @(posedge clk);
    wdog <= 1'b0;
    rd_chk("wdog cause", `WEL_OFS_RESET_CAUSE, 8'h10);
    cold <= 1'b1;
    @(posedge clk);
    cold <= 1'b0;
    rd_chk("cold cause", `WEL_OFS_RESET_CAUSE, 8'h80);
    wr_reg(`WEL_OFS_WAKE_SOURCE, 8'hff);
    rd_chk("ro flags", `WEL_OFS_WAKE_SOURCE, 8'h00);
    wr_reg(`WEL_OFS_PIN_ENABLE, 8'h1f);
    rd_chk("enables rw", `WEL_OFS_PIN_ENABLE, 8'h1f);
    $display("test regs done");
  endtask
  task automatic t_serial();
    wr_reg(`WEL_OFS_PIN_ENABLE, 8'h10);
    go_sleep(8'h80);
    rd_chk("cause cleared", `WEL_OFS_RESET_CAUSE, 8'h00);
    pins.drive(1, 1'b0, 10);
    wait_wake(1'b1, 1000);
    `CHK("mode", wel_pkg::WEL_BROWNOUT_BATTERY_MODE, mode)
    `CHK("cpu reset", 1'b1, cpu_resetn)
    rd_chk("serial flag", `WEL_OFS_WAKE_SOURCE, 8'h10);
    pins.drive(1, 1'b1, 10);
    rd_chk("flag kept", `WEL_OFS_WAKE_SOURCE, 8'h10);
    $display("test serial done");
  endtask
  task automatic t_pin_four();
    wr_reg(`WEL_OFS_PIN_ENABLE, 8'h04);
    go_sleep(8'h80);
    pins.drive(2, 1'b1, 600);
    `CHK("unconfigured wake", 1'b0, wake)
    rd_chk("unconfigured flag", `WEL_OFS_WAKE_SOURCE, 8'h00);
    pins.drive(2, 1'b0, 10);
    cfg <= 3'b001;
    pins.drive(2, 1'b1, 10);
    wait_wake(1'b1, 1000);
    rd_chk("pin four flag", `WEL_OFS_WAKE_SOURCE, 8'h04);
    pins.drive(2, 1'b0, 10);
    $display("test pin four done");
  endtask
  task automatic t_button();
    wr_reg(`WEL_OFS_PIN_ENABLE, 8'h08);
    go_sleep(8'h80);
    pins.drive(0, 1'b1, 500);
    `CHK("early wake", 1'b0, wake)
    wait_wake(1'b1, 1500);
    rd_chk("button flag", `WEL_OFS_WAKE_SOURCE, 8'h08);
    pins.drive(0, 1'b0, 10);
    $display("test button done");
  endtask
  task automatic t_optical();
    wr_reg(`WEL_OFS_PIN_ENABLE, 8'h01);
    cfg <= 3'b101;
    go_sleep(8'h80);
    pins.drive(3, 1'b0, 10);
    wait_wake(1'b1, 1000);
    rd_chk("pin 55 flag", `WEL_OFS_WAKE_SOURCE, 8'h01);
    pins.drive(3, 1'b1, 10);
    rd_chk("optical kept", `WEL_OFS_WAKE_SOURCE, 8'h01);
    $display("test optical done");
  endtask
  task automatic t_timer();
    wr_reg(`WEL_OFS_TIMER_PERIOD, 8'h02);
    go_sleep(8'ha0);
    wait_wake(1'b1, 200);
    rd_chk("timer flag", `WEL_OFS_WAKE_SOURCE, 8'h20);
    wr_reg(`WEL_OFS_TIMER_ARM, 8'h00);
    $display("test timer done");
  endtask
  task automatic t_power();
    go_sleep(8'h80);
    power_ok <= 1'b1;
    wait_wake(1'b1, 20);
    `CHK("mode", wel_pkg::WEL_MISSION_FULL_POWER_MODE, mode)
    rd_chk("no flag", `WEL_OFS_WAKE_SOURCE, 8'h00);
    $display("test power done");
  endtask
  initial begin
    resetn = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 16'h0000;
    wdata = 8'h00;
    cfg = 3'b000;
    power_ok = 1'b0;
    sw_rst = 1'b0;
    wdog = 1'b0;
    cold = 1'b0;
    bad_count = 0;
    n_compared = 0;
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    // short filters leave reset low: let the idle-high lines settle first
    repeat (600) @(posedge clk);
    t_regs();
    t_serial();
    t_pin_four();
    t_button();
    t_optical();
    t_timer();
    t_power();
    close_out();
  end
endmodule // tb
